// ==== hdl/vic_cfg.svh ====
// register offsets, field positions, reset values and vectors of the interrupt controller
`ifndef VIC_CFG_SVH
`define VIC_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define VIC_OFF_CTRL_ZERO    5'h00
`define VIC_OFF_CTRL_ONE     5'h04
`define VIC_OFF_CTRL_TWO     5'h08
`define VIC_OFF_GROUP0       5'h0C
`define VIC_OFF_GROUP1       5'h10
`define VIC_OFF_GROUP2       5'h14
`define VIC_OFF_EDGE_SEL     5'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define VIC_GIE_BIT          0
`define VIC_FLAG_LSB         4
`define VIC_EN_LSB           0
`define VIC_MF_FLAG_LSB      4
`define VIC_MF_EN_LSB        0
`define VIC_EDGE_LSB         2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define VIC_RST_BYTE         8'h00
`define VIC_RST_EDGE         2'h0

// ----------------------------------------------------------------
// edge select codes
// ----------------------------------------------------------------
`define VIC_EDGE_OFF         2'h0
`define VIC_EDGE_RISE        2'h1
`define VIC_EDGE_FALL        2'h2
`define VIC_EDGE_BOTH        2'h3

// ----------------------------------------------------------------
// vector addresses, ascending = falling priority
// ----------------------------------------------------------------
`define VIC_VEC_EXT          12'h004
`define VIC_VEC_GRP0         12'h008
`define VIC_VEC_GRP1         12'h00C
`define VIC_VEC_GRP2         12'h010
`define VIC_VEC_TBA          12'h014
`define VIC_VEC_TBB          12'h018
`define VIC_VEC_TWI          12'h01C

`endif

// ==== hdl/vic_pkg.sv ====
// types shared by the interrupt controller files
package vic_pkg;

  typedef enum logic [1:0] {
    VIC_ST_IDLE   = 2'b01,
    VIC_ST_VECTOR = 2'b10
  } vic_state_e;

  typedef logic [7:0]  vic_byte_t;
  typedef logic [11:0] vic_addr_t;

endpackage

// ==== hdl/vic_pin_edge.sv ====
// external pin synchroniser and edge detector
`timescale 1ns/1ns
`include "vic_cfg.svh"

module vic_pin_edge (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // pin and control
  input  wire logic       pin_raw,
  input  wire logic       detect_en,
  input  wire logic [1:0] edge_sel,
  // event
  output logic            edge_evt
);

  logic [2:0] sync;
  logic [2:0] next_sync;
  logic       level;
  logic       next_level;
  logic       next_edge_evt;
  logic       hit;

  always_comb begin
    next_sync = {sync[1:0], pin_raw};
    // a change only counts once the second and third stage agree
    next_level = (sync[1] == sync[2]) ? sync[2] : level;
    unique case (edge_sel)
      `VIC_EDGE_RISE: hit = next_level & ~level;
      `VIC_EDGE_FALL: hit = ~next_level & level;
      `VIC_EDGE_BOTH: hit = next_level ^ level;
      `VIC_EDGE_OFF:  hit = 1'b0;
    endcase
    next_edge_evt = detect_en & hit;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync     <= 3'h0;
      level    <= 1'b0;
      edge_evt <= 1'b0;
    end else begin
      sync     <= next_sync;
      level    <= next_level;
      edge_evt <= next_edge_evt;
    end
  end

endmodule // vic_pin_edge

// ==== hdl/vic_top.sv ====
// vectored interrupt controller with avalon-mm register slave
`timescale 1ns/1ns
`include "vic_cfg.svh"

module vic_top (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // peripheral events, one-cycle pulses
  input  wire logic        timebase_a_evt,
  input  wire logic        timebase_b_evt,
  input  wire logic        twowire_evt,
  input  wire logic        tmr_a_cmpa_evt,
  input  wire logic        tmr_a_cmpp_evt,
  input  wire logic        tmr_b_cmpa_evt,
  input  wire logic        tmr_b_cmpp_evt,
  input  wire logic        eeprom_done_evt,
  input  wire logic        lowvolt_evt,
  // external pin
  input  wire logic        ext_irq_pin,
  input  wire logic        ext_pin_is_input,
  input  wire logic        ext_pin_pullup_sel,
  output logic             ext_pin_pullup_en,
  // core side
  input  wire logic        core_insn_end,
  input  wire logic [11:0] core_next_pc,
  input  wire logic        core_return_from_irq_instr,
  input  wire logic        stack_full,
  output logic             stack_push,
  output logic [11:0]      stack_push_pc,
  output logic             stack_pop,
  output logic             pc_load,
  output logic [11:0]      pc_load_addr,
  output logic             wake_req
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync;
  logic       rst_n;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_n = rst_sync[1];

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // register select, shared by the read and write paths; 7 = unmapped
  function automatic logic [2:0] reg_sel(input logic [4:0] addr);
    unique case (addr)
      `VIC_OFF_CTRL_ZERO: reg_sel = 3'h0;
      `VIC_OFF_CTRL_ONE:  reg_sel = 3'h1;
      `VIC_OFF_CTRL_TWO:  reg_sel = 3'h2;
      `VIC_OFF_GROUP0:    reg_sel = 3'h3;
      `VIC_OFF_GROUP1:    reg_sel = 3'h4;
      `VIC_OFF_GROUP2:    reg_sel = 3'h5;
      `VIC_OFF_EDGE_SEL:  reg_sel = 3'h6;
      default:            reg_sel = 3'h7;
    endcase
  endfunction

  // lowest set index wins; index order follows vector order
  function automatic logic [2:0] first_set(input logic [6:0] req);
    first_set = 3'h0;
    for (int i = 6; i >= 0; i--) begin
      if (req[i]) begin
        first_set = 3'(i);
      end
    end
  endfunction

  function automatic vic_pkg::vic_addr_t vec_of(input logic [2:0] idx);
    unique case (idx)
      3'h0:    vec_of = `VIC_VEC_EXT;
      3'h1:    vec_of = `VIC_VEC_GRP0;
      3'h2:    vec_of = `VIC_VEC_GRP1;
      3'h3:    vec_of = `VIC_VEC_GRP2;
      3'h4:    vec_of = `VIC_VEC_TBA;
      3'h5:    vec_of = `VIC_VEC_TBB;
      default: vec_of = `VIC_VEC_TWI;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  vic_pkg::vic_state_e state;
  vic_pkg::vic_state_e next_state;
  logic                global_irq_en;
  logic                next_global_irq_en;
  // control two: [3] ext pin, [2] time base b, [1] time base a, [0] two-wire
  logic [3:0]          c2_flag;
  logic [3:0]          next_c2_flag;
  logic [3:0]          c2_en;
  logic [3:0]          next_c2_en;
  logic [2:0]          group_req_flags;
  logic [2:0]          next_group_req_flags;
  logic [2:0]          group_en;
  logic [2:0]          next_group_en;
  // members per group: [1] comparator a / eeprom, [0] comparator p / low-voltage
  logic [1:0]          mf_flag [3];
  logic [1:0]          next_mf_flag [3];
  logic [1:0]          mf_en [3];
  logic [1:0]          next_mf_en [3];
  logic [1:0]          mf_evt [3];
  logic [1:0]          edge_select_reg;
  logic [1:0]          next_edge_select_reg;
  logic                next_avs_waitrequest;
  logic [31:0]         next_avs_readdata;
  logic                next_stack_push;
  logic [11:0]         next_stack_push_pc;
  logic                next_pc_load;
  logic [11:0]         next_pc_load_addr;
  logic                next_wake_req;
  logic                ext_edge_evt;

  // ----------------------------------------------------------------
  // external pin edge detection
  // ----------------------------------------------------------------
  vic_pin_edge u_pin_edge (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .pin_raw   (ext_irq_pin),
    .detect_en (c2_en[3] & ext_pin_is_input),
    .edge_sel  (edge_select_reg),
    .edge_evt  (ext_edge_evt)
  );

  assign mf_evt[0] = {tmr_a_cmpa_evt, tmr_a_cmpp_evt};
  assign mf_evt[1] = {tmr_b_cmpa_evt, tmr_b_cmpp_evt};
  assign mf_evt[2] = {eeprom_done_evt, lowvolt_evt};

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic             taken;
    logic [2:0]       sel;
    logic [6:0]       pend;
    logic [2:0]       win;
    logic [7:0]       wd;
    vic_pkg::vic_byte_t rd;
    logic [13:0]      old_all;
    logic [13:0]      new_all;

    taken                = 1'b0;
    sel                  = reg_sel(avs_address);
    pend                 = 7'h00;
    win                  = 3'h0;
    wd                   = avs_writedata[7:0];
    rd                   = `VIC_RST_BYTE;
    old_all              = 14'h0000;
    new_all              = 14'h0000;
    next_state           = state;
    next_global_irq_en   = global_irq_en;
    next_c2_flag         = c2_flag;
    next_c2_en           = c2_en;
    next_group_req_flags = group_req_flags;
    next_group_en        = group_en;
    next_mf_flag         = mf_flag;
    next_mf_en           = mf_en;
    next_edge_select_reg = edge_select_reg;
    next_stack_push      = 1'b0;
    next_stack_push_pc   = stack_push_pc;
    next_pc_load         = 1'b0;
    next_pc_load_addr    = pc_load_addr;
    next_avs_readdata    = avs_readdata;

    // bus: waitrequest drops for exactly one cycle per request
    next_avs_waitrequest = 1'b1;
    if ((avs_read | avs_write) & avs_waitrequest) begin
      next_avs_waitrequest = 1'b0;
      unique case (sel)
        3'h0: rd = {7'h00, global_irq_en};
        3'h1: rd = {1'b0, group_req_flags, 1'b0, group_en};
        3'h2: rd = {c2_flag, c2_en};
        3'h3: rd = {2'b00, mf_flag[0], 2'b00, mf_en[0]};
        3'h4: rd = {2'b00, mf_flag[1], 2'b00, mf_en[1]};
        3'h5: rd = {2'b00, mf_flag[2], 2'b00, mf_en[2]};
        3'h6: rd = {4'h0, edge_select_reg, 2'b00};
        3'h7: rd = `VIC_RST_BYTE;
      endcase
      next_avs_readdata = {24'h000000, rd};
    end

    // software writes take effect on the edge that ends the cycle with waitrequest low
    if (avs_write & ~avs_waitrequest & avs_byteenable[0]) begin
      unique case (sel)
        3'h0: next_global_irq_en = wd[`VIC_GIE_BIT];
        3'h1: begin
          next_group_req_flags = wd[`VIC_FLAG_LSB +: 3];
          next_group_en        = wd[`VIC_EN_LSB +: 3];
        end
        3'h2: begin
          next_c2_flag = wd[`VIC_FLAG_LSB +: 4];
          next_c2_en   = wd[`VIC_EN_LSB +: 4];
        end
        3'h3: begin
          next_mf_flag[0] = wd[`VIC_MF_FLAG_LSB +: 2];
          next_mf_en[0]   = wd[`VIC_MF_EN_LSB +: 2];
        end
        3'h4: begin
          next_mf_flag[1] = wd[`VIC_MF_FLAG_LSB +: 2];
          next_mf_en[1]   = wd[`VIC_MF_EN_LSB +: 2];
        end
        3'h5: begin
          next_mf_flag[2] = wd[`VIC_MF_FLAG_LSB +: 2];
          next_mf_en[2]   = wd[`VIC_MF_EN_LSB +: 2];
        end
        3'h6: next_edge_select_reg = wd[`VIC_EDGE_LSB +: 2];
        3'h7: next_global_irq_en = global_irq_en;
      endcase
    end

    // pending requests, index order = ascending vector
    pend[0] = c2_flag[3] & c2_en[3];
    for (int g = 0; g < 3; g++) begin
      // a group needs its own enable and at least one enabled member
      pend[g + 1] = group_req_flags[g] & group_en[g]
                  & (|(mf_flag[g] & mf_en[g]));
    end
    pend[4] = c2_flag[1] & c2_en[1];
    pend[5] = c2_flag[2] & c2_en[2];
    pend[6] = c2_flag[0] & c2_en[0];
    win     = first_set(pend);

    // take at an instruction boundary only; a full stack holds it pending
    unique case (state)
      vic_pkg::VIC_ST_IDLE: begin
        if (core_insn_end & global_irq_en & ~stack_full & (|pend)) begin
          taken              = 1'b1;
          next_state         = vic_pkg::VIC_ST_VECTOR;
          next_stack_push    = 1'b1;
          next_stack_push_pc = core_next_pc;
          next_pc_load       = 1'b1;
          next_pc_load_addr  = vec_of(win);
          next_global_irq_en = 1'b0;
        end
      end
      // one settling cycle so the cleared global enable is seen
      vic_pkg::VIC_ST_VECTOR: next_state = vic_pkg::VIC_ST_IDLE;
    endcase

    // service clears the winner; group members are left alone
    if (taken) begin
      unique case (win)
        3'h0:    next_c2_flag[3] = 1'b0;
        3'h1:    next_group_req_flags[0] = 1'b0;
        3'h2:    next_group_req_flags[1] = 1'b0;
        3'h3:    next_group_req_flags[2] = 1'b0;
        3'h4:    next_c2_flag[1] = 1'b0;
        3'h5:    next_c2_flag[2] = 1'b0;
        default: next_c2_flag[0] = 1'b0;
      endcase
    end

    // events set flags after any clear, so a set in the clear cycle wins
    next_c2_flag = next_c2_flag
                 | {ext_edge_evt, timebase_b_evt, timebase_a_evt, twowire_evt};
    for (int g = 0; g < 3; g++) begin
      next_mf_flag[g] = next_mf_flag[g] | mf_evt[g];
      if (|(next_mf_flag[g] & ~mf_flag[g])) begin
        next_group_req_flags[g] = 1'b1;
      end
    end

    // wake on any flag going high, whatever the enables
    old_all = {c2_flag, group_req_flags, mf_flag[0], mf_flag[1], mf_flag[2], 1'b0};
    new_all = {next_c2_flag, next_group_req_flags,
               next_mf_flag[0], next_mf_flag[1], next_mf_flag[2], 1'b0};
    next_wake_req = |(new_all & ~old_all);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state             <= vic_pkg::VIC_ST_IDLE;
      global_irq_en     <= 1'b0;
      c2_flag           <= 4'h0;
      c2_en             <= 4'h0;
      group_req_flags   <= 3'h0;
      group_en          <= 3'h0;
      edge_select_reg   <= `VIC_RST_EDGE;
      avs_waitrequest   <= 1'b1;
      avs_readdata      <= 32'h00000000;
      stack_push        <= 1'b0;
      stack_push_pc     <= 12'h000;
      stack_pop         <= 1'b0;
      pc_load           <= 1'b0;
      pc_load_addr      <= 12'h000;
      wake_req          <= 1'b0;
      ext_pin_pullup_en <= 1'b0;
    end else begin
      state             <= next_state;
      global_irq_en     <= next_global_irq_en;
      c2_flag           <= next_c2_flag;
      c2_en             <= next_c2_en;
      group_req_flags   <= next_group_req_flags;
      group_en          <= next_group_en;
      edge_select_reg   <= next_edge_select_reg;
      avs_waitrequest   <= next_avs_waitrequest;
      avs_readdata      <= next_avs_readdata;
      stack_push        <= next_stack_push;
      stack_push_pc     <= next_stack_push_pc;
      stack_pop         <= core_return_from_irq_instr;
      pc_load           <= next_pc_load;
      pc_load_addr      <= next_pc_load_addr;
      wake_req          <= next_wake_req;
      ext_pin_pullup_en <= ext_pin_pullup_sel;
    end
  end

  // group member registers, one copy per group
  generate
    for (genvar g = 0; g < 3; g++) begin : g_group
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          mf_flag[g] <= 2'h0;
          mf_en[g]   <= 2'h0;
        end else begin
          mf_flag[g] <= next_mf_flag[g];
          mf_en[g]   <= next_mf_en[g];
        end
      end
    end
  endgenerate

endmodule // vic_top

// ==== bench/vic_top_chk.sv ====
// port assertions for the vectored interrupt controller
`timescale 1ns/1ns
`include "vic_cfg.svh"

module vic_top_chk (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        resetn,
  // bus side
  input wire logic [31:0] avs_readdata,
  // pin side
  input wire logic        ext_pin_pullup_sel,
  input wire logic        ext_pin_pullup_en,
  // core side
  input wire logic        core_insn_end,
  input wire logic [11:0] core_next_pc,
  input wire logic        core_return_from_irq_instr,
  input wire logic        stack_full,
  input wire logic        stack_push,
  input wire logic [11:0] stack_push_pc,
  input wire logic        stack_pop,
  input wire logic        pc_load,
  input wire logic [11:0] pc_load_addr,
  input wire logic        wake_req
);
  // ------------------------------------------------
  // properties
  // ------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  property p_push_pair;
    stack_push |-> pc_load && stack_push_pc == $past(core_next_pc);
  endproperty
  a_push_pair: assert property (p_push_pair) else $error("push without load");
  property p_push_gate;
    stack_push |-> $past(core_insn_end) && !$past(stack_full);
  endproperty
  a_push_gate: assert property (p_push_gate) else $error("take while full");
  property p_one_take;
    stack_push |=> !stack_push [*2];
  endproperty
  a_one_take: assert property (p_one_take) else $error("nested take");
  property p_vec;
    pc_load |-> pc_load_addr inside {`VIC_VEC_EXT, `VIC_VEC_GRP0, `VIC_VEC_GRP1,
      `VIC_VEC_GRP2, `VIC_VEC_TBA, `VIC_VEC_TBB, `VIC_VEC_TWI};
  endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_ret;
    core_return_from_irq_instr |=> stack_pop;
  endproperty
  a_ret: assert property (p_ret) else $error("no pop on return");
  property p_pop_cause;
    stack_pop |-> $past(core_return_from_irq_instr);
  endproperty
  a_pop_cause: assert property (p_pop_cause) else $error("stray pop");
  property p_pull;
    ext_pin_pullup_en == $past(ext_pin_pullup_sel);
  endproperty
  a_pull: assert property (p_pull) else $error("pull-high lost");
  property p_hi;
    avs_readdata[31:8] == 24'h000000;
  endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");

  c_push: cover property (stack_push);
  c_pop: cover property (stack_pop);
  c_wake: cover property (wake_req);
endmodule // vic_top_chk

// ==== bench/vic_core_model.sv ====
// core side model: program counter and hardware stack
`timescale 1ns/1ns

module vic_core_model #(parameter int DEPTH = 8) (
  // clock
  input wire logic        sys_clk,
  // controller side
  input wire logic        stack_push,
  input wire logic [11:0] stack_push_pc,
  input wire logic        stack_pop,
  input wire logic        pc_load,
  input wire logic [11:0] pc_load_addr,
  // core outputs
  output logic [11:0]     core_next_pc,
  output logic            stack_full,
  output logic            core_insn_end
);
  // ------------------------------------------------
  // stack
  // ------------------------------------------------
  logic [11:0] stk [0:7];
  int          depth = 0;
  logic [1:0]  phase = 2'h0;

  initial core_next_pc = 12'h100;
  // every fourth cycle is mid-instruction, so a take must wait for a boundary
  assign core_insn_end = (phase != 2'h3);
  assign stack_full = (depth >= DEPTH);
  always @(posedge sys_clk) begin
    phase <= phase + 2'h1;
    if (pc_load) begin
      core_next_pc <= pc_load_addr;
    end else if (stack_pop && depth > 0) begin
      core_next_pc <= stk[depth-1];
    end else begin
      core_next_pc <= core_next_pc + 12'h001;
    end
    if (stack_push) begin
      stk[depth] <= stack_push_pc;
      depth <= depth + 1;
    end else if (stack_pop && depth > 0) begin
      depth <= depth - 1;
    end
  end
endmodule // vic_core_model

// ==== bench/test_vectored_irq_controller.sv ====
// self-checking bench for the vectored interrupt controller
`timescale 1ns/1ns
`include "vic_cfg.svh"

module test_vectored_irq_controller;
  logic        sys_clk = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [31:0] avs_writedata = 32'h00000000, avs_readdata;
  logic [8:0]  evts = 9'h000;
  logic        pin = 1'b0, pin_in = 1'b1, pull_sel = 1'b0, core_return_from_irq_instr = 1'b0;
  logic        avs_waitrequest, pull_en, insn_end, stack_full, stack_push, stack_pop;
  logic        pc_load, wake_req;
  logic [11:0] next_pc, push_pc, pc_load_addr;
  int          failures = 0, comparisons = 0;
  logic [4:0]  ea [0:8] = '{5'h08, 5'h08, 5'h08, 5'h0C, 5'h0C, 5'h10, 5'h10, 5'h14, 5'h14};
  logic [7:0]  em [0:8] = '{8'h20, 8'h40, 8'h10, 8'h20, 8'h10, 8'h20, 8'h10, 8'h20, 8'h10};
  logic [7:0]  acc [0:7] = '{default: 8'h00};
  logic [4:0]  ra [0:4] = '{5'h08, 5'h0C, 5'h10, 5'h14, 5'h1C};
  logic [7:0]  rm [0:4] = '{8'hFF, 8'h33, 8'h33, 8'h33, 8'h00};
  logic [11:0] vt [0:5] = '{`VIC_VEC_GRP0, `VIC_VEC_GRP1, `VIC_VEC_GRP2,
                            `VIC_VEC_TBA, `VIC_VEC_TBB, `VIC_VEC_TWI};

  vic_top dut (.sys_clk(sys_clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .timebase_a_evt(evts[0]), .timebase_b_evt(evts[1]),
    .twowire_evt(evts[2]), .tmr_a_cmpa_evt(evts[3]), .tmr_a_cmpp_evt(evts[4]),
    .tmr_b_cmpa_evt(evts[5]), .tmr_b_cmpp_evt(evts[6]), .eeprom_done_evt(evts[7]),
    .lowvolt_evt(evts[8]), .ext_irq_pin(pin), .ext_pin_is_input(pin_in),
    .ext_pin_pullup_sel(pull_sel), .ext_pin_pullup_en(pull_en), .core_insn_end(insn_end),
    .core_next_pc(next_pc), .core_return_from_irq_instr(core_return_from_irq_instr), .stack_full(stack_full),
    .stack_push(stack_push), .stack_push_pc(push_pc), .stack_pop(stack_pop),
    .pc_load(pc_load), .pc_load_addr(pc_load_addr), .wake_req(wake_req));

  vic_core_model #(.DEPTH(2)) core (.sys_clk(sys_clk), .stack_push(stack_push),
    .stack_push_pc(push_pc), .stack_pop(stack_pop), .pc_load(pc_load),
    .pc_load_addr(pc_load_addr), .core_next_pc(next_pc), .stack_full(stack_full),
    .core_insn_end(insn_end));

  initial begin
    forever #20 sys_clk = !sys_clk;
  end

  // ------------------------------------------------
  // tasks
  // ------------------------------------------------
  task automatic summarize();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= 4'hF;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50) begin
      failures++;
      summarize();
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input string nm, input logic [4:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(nm, {4'h0, q}, {4'h0, e});
  endtask
  task automatic watch(input int n, input logic [11:0] v, input logic exp);
    logic took;
    took = 1'b0;
    for (int i = 0; i < n && !took; i++) begin
      @(posedge sys_clk);
      if (stack_push === 1'b1) begin
        took = 1'b1;
        chk("vector", pc_load_addr, v);
      end
    end
    chk("taken", {11'h000, took}, {11'h000, exp});
    if (exp && !took) begin
      summarize();
    end
  endtask
  task automatic pulse(input int i, input logic e);
    logic w;
    w = 1'b0;
    @(posedge sys_clk);
    evts <= 9'h001 << i;
    @(posedge sys_clk);
    evts <= 9'h000;
    repeat (4) begin
      @(posedge sys_clk);
      w = w | (wake_req === 1'b1);
    end
    chk("wake", {11'h000, w}, {11'h000, e});
  endtask
  task automatic return_from_irq_instr();
    @(posedge sys_clk);
    core_return_from_irq_instr <= 1'b1;
    @(posedge sys_clk);
    core_return_from_irq_instr <= 1'b0;
  endtask
  // the pin passes a three-flop synchroniser, so allow eight cycles per change
  task automatic toggle();
    @(posedge sys_clk);
    pin <= !pin;
    repeat (8) @(posedge sys_clk);
  endtask

  // ------------------------------------------------
  // stimulus
  // ------------------------------------------------
  initial begin
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    for (int a = 0; a < 32; a += 4) rd("reset value", 5'(a), 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 5; i++) begin
      wr(ra[i], 8'hFF);
      rd("mask", ra[i], rm[i]);
      wr(ra[i], 8'h00);
    end
    wr(5'h04, 8'h00);
    $display("test register masks done");
    for (int i = 0; i < 9; i++) begin
      pulse(i, 1'b1);
      acc[ea[i][4:2]] = acc[ea[i][4:2]] | em[i];
      rd("flag", ea[i], acc[ea[i][4:2]]);
    end
    rd("group flags", 5'h04, 8'h70);
    pulse(0, 1'b0);
    wr(5'h00, 8'h01);
    watch(20, 12'h000, 1'b0);
    wr(5'h00, 8'h00);
    wr(5'h08, 8'h77);
    wr(5'h0C, 8'h33);
    wr(5'h10, 8'h33);
    wr(5'h14, 8'h33);
    wr(5'h04, 8'h77);
    watch(20, 12'h000, 1'b0);
    $display("test events done");
    for (int i = 0; i < 6; i++) begin
      wr(5'h00, 8'h01);
      watch(20, vt[i], 1'b1);
      rd("global", 5'h00, 8'h00);
      if (i == 0) rd("group flags", 5'h04, 8'h67);
      if (i == 0) rd("member flags", 5'h0C, 8'h33);
      return_from_irq_instr();
    end
    $display("test priority done");
    for (int i = 0; i < 3; i++) begin
      pulse(i, 1'b1);
      wr(5'h00, 8'h01);
      watch(30, vt[i+3], i < 2);
    end
    return_from_irq_instr();
    watch(20, `VIC_VEC_TWI, 1'b1);
    repeat (2) return_from_irq_instr();
    $display("test stack full done");
    pull_sel <= 1'b1;
    wr(5'h08, 8'h08);
    for (int c = 0; c < 4; c++) begin
      wr(5'h18, 8'(c << 2));
      for (int j = 0; j < 2; j++) begin
        toggle();
        rd("pin flag", 5'h08, c[j] ? 8'h88 : 8'h08);
        wr(5'h08, 8'h08);
      end
    end
    pin_in <= 1'b0;
    toggle();
    rd("pin flag", 5'h08, 8'h08);
    pin_in <= 1'b1;
    toggle();
    wr(5'h00, 8'h01);
    watch(20, `VIC_VEC_EXT, 1'b1);
    rd("pin flag", 5'h08, 8'h08);
    return_from_irq_instr();
    $display("test external pin done");
    summarize();
  end
endmodule // test_vectored_irq_controller

bind vic_top vic_top_chk chk (.sys_clk(sys_clk), .resetn(resetn), .avs_readdata(avs_readdata),
  .ext_pin_pullup_sel(ext_pin_pullup_sel), .ext_pin_pullup_en(ext_pin_pullup_en),
  .core_insn_end(core_insn_end), .core_next_pc(core_next_pc), .core_return_from_irq_instr(core_return_from_irq_instr),
  .stack_full(stack_full), .stack_push(stack_push), .stack_push_pc(stack_push_pc),
  .stack_pop(stack_pop), .pc_load(pc_load), .pc_load_addr(pc_load_addr), .wake_req(wake_req));
